//--- rtl/cos_defines.vh
// constants for the operand and status logic of the core
// Function
// - add sets overflow on same-sign wrong-sign result
// - subtract and compare overflow on mixed-sign flip
// - upper clock bit stops unused oscillator dc generator
// - lower clock bit halts locked-loop control
// - xtal stop bit stops unused crystal oscillator
// - core halt bit stops instruction execution
// - maskable interrupts pass only while permitted
// - word result bit 15 loads msb flag
// - byte result bit 7 loads msb flag
// - all-clear flag set on zero result
// - top-spill flag follows carry out
// - two registers supply six source constants
// - constant registers act as sources only
// - twelve general registers, byte and word access
// - seven source, four destination modes; 00/0 register
// - indexed mode addresses register plus offset word
// - indexed on instruction pointer gives symbolic address
// - indexed on status register gives absolute address
// - source mode 10 uses register as pointer
// - mode 11 fetches then increments by 1 or 2
// - mode 11 on instruction pointer gives immediate
// - destinations: register, indexed, symbolic, absolute
// - byte register writes clear upper byte
// - status word ordinary only as word register
`ifndef COS_DEFINES_VH
`define COS_DEFINES_VH

// status word bit positions
`define COS_SR_C      0
`define COS_SR_Z      1
`define COS_SR_N      2
`define COS_SR_GIE    3
`define COS_SR_HALT   4
`define COS_SR_XOFF   5
`define COS_SR_LCLK   6
`define COS_SR_UCLK   7
`define COS_SR_V      8
`define COS_SR_W      9
`define COS_SR_RST    9'h000
`define COS_SR_PAD    7'h00

// register numbers
`define COS_R_PC      4'h0
`define COS_R_SP      4'h1
`define COS_R_SR      4'h2
`define COS_R_CG      4'h3
`define COS_R_GP0     4'h4

// addressing mode codes
`define COS_AS_REG    2'b00
`define COS_AS_IDX    2'b01
`define COS_AS_IND    2'b10
`define COS_AS_INC    2'b11

// constant generator values
`define COS_K_0       16'h0000
`define COS_K_1       16'h0001
`define COS_K_2       16'h0002
`define COS_K_4       16'h0004
`define COS_K_8       16'h0008
`define COS_K_M1      16'hffff

// autoincrement steps and byte handling
`define COS_INC_B     16'h0001
`define COS_INC_W     16'h0002
`define COS_LO_MASK   16'h00ff
`define COS_MSB_B     7
`define COS_MSB_W     15
`define COS_NGPR      12

// flag update kinds
`define COS_K_OTHER   2'b00
`define COS_K_ADD     2'b01
`define COS_K_SUB     2'b10

`define COS_ZERO16    16'h0000

`endif

//--- rtl/cos_operand_status.v
// operand decode, constant sources, registers and status word
//
// Our own choices: the register addresses and strobed register access.
`timescale 1ns/1ps
`include "cos_defines.vh"

module cos_operand_status (
  // clock and reset
  input  wire        i_sys_clk,
  input  wire        i_sys_rst,
  // register port
  input  wire [3:0]  i_reg_addr,
  input  wire [15:0] i_reg_wdata,
  input  wire        i_reg_wr,
  input  wire        i_reg_rd,
  output reg  [15:0] o_reg_rdata,
  // operand decode request
  input  wire        i_dec_valid,
  input  wire        i_dec_byte,
  input  wire [3:0]  i_src_reg,
  input  wire [1:0]  i_src_mode,
  input  wire [15:0] i_src_ext,
  input  wire [3:0]  i_dst_reg,
  input  wire        i_dst_mode,
  input  wire [15:0] i_dst_ext,
  input  wire [15:0] i_pc,
  input  wire [15:0] i_sp,
  // operand decode answer
  output reg         o_dec_valid,
  output reg  [15:0] o_src_val,
  output reg  [15:0] o_src_addr,
  output reg         o_src_fetch,
  output reg         o_src_ext_used,
  output reg  [15:0] o_dst_val,
  output reg  [15:0] o_dst_addr,
  output reg         o_dst_mem,
  output reg         o_dst_ext_used,
  // flag update from alu
  input  wire        i_alu_valid,
  input  wire [1:0]  i_alu_kind,
  input  wire        i_alu_byte,
  input  wire [15:0] i_alu_a,
  input  wire [15:0] i_alu_b,
  input  wire [15:0] i_alu_res,
  input  wire        i_alu_carry,
  input  wire        i_alu_v,
  // register writeback
  input  wire        i_wb_en,
  input  wire        i_wb_byte,
  input  wire [3:0]  i_wb_reg,
  input  wire [15:0] i_wb_data,
  // interrupt and clock selection
  input  wire        i_irq_req,
  input  wire        i_dco_main,
  input  wire        i_dco_sub,
  input  wire        i_xt_main,
  input  wire        i_xt_sub,
  // core and clock control
  output reg         o_irq_take,
  output reg         o_core_halt,
  output reg         o_dco_dc_off,
  output reg         o_fll_hold,
  output reg         o_xtal_stop,
  output reg  [15:0] o_status
);

  reg [`COS_SR_W-1:0] sr_q;
  reg [`COS_SR_W-1:0] sr_d;
  reg [15:0]          gpr_q [0:11];
  reg [15:0]          src_val_d;
  reg [15:0]          src_addr_d;
  reg                 src_fetch_d;
  reg                 src_ext_d;
  reg                 inc_d;
  reg [15:0]          dst_val_d;
  reg [15:0]          dst_addr_d;
  reg                 dst_mem_d;
  reg                 dst_ext_d;
  reg [15:0]          rd_d;
  reg [15:0]          wb_val;
  reg                 sa;
  reg                 sb;
  reg                 sres;
  integer             k;

  // general register slot from register number
  function [3:0] gidx;
    input [3:0] r;
    begin
      gidx = r - `COS_R_GP0;
    end
  endfunction

  // current value of any register as an address base
  function [15:0] rval;
    input [3:0] r;
    begin
      case (r)
        `COS_R_PC: rval = i_pc;
        `COS_R_SP: rval = i_sp;
        `COS_R_SR: rval = {`COS_SR_PAD, sr_q};
        `COS_R_CG: rval = `COS_K_0;
        default:   rval = gpr_q[gidx(r)];
      endcase
    end
  endfunction

  // sign bit of a byte or word value
  function sgn;
    input [15:0] v;
    input        b;
    begin
      sgn = b ? v[`COS_MSB_B] : v[`COS_MSB_W];
    end
  endfunction

  // source operand decode
  always @* begin
    src_val_d   = `COS_ZERO16;
    src_addr_d  = `COS_ZERO16;
    src_fetch_d = 1'b0;
    src_ext_d   = 1'b0;
    inc_d       = 1'b0;
    case (i_src_mode)
      `COS_AS_REG: begin
        if (i_src_reg == `COS_R_CG)
          src_val_d = `COS_K_0;
        else
          src_val_d = rval(i_src_reg);
      end
      `COS_AS_IDX: begin
        if (i_src_reg == `COS_R_CG) begin
          src_val_d = `COS_K_1;
        end else begin
          src_fetch_d = 1'b1;
          src_ext_d   = 1'b1;
          if (i_src_reg == `COS_R_SR)
            src_addr_d = i_src_ext;
          else
            // pc base covers symbolic form
            src_addr_d = rval(i_src_reg) + i_src_ext;
        end
      end
      `COS_AS_IND: begin
        if (i_src_reg == `COS_R_SR)
          src_val_d = `COS_K_4;
        else if (i_src_reg == `COS_R_CG)
          src_val_d = `COS_K_2;
        else begin
          src_addr_d  = rval(i_src_reg);
          src_fetch_d = 1'b1;
        end
      end
      `COS_AS_INC: begin
        if (i_src_reg == `COS_R_SR)
          src_val_d = `COS_K_8;
        else if (i_src_reg == `COS_R_CG)
          src_val_d = `COS_K_M1;
        else if (i_src_reg == `COS_R_PC) begin
          src_val_d = i_src_ext;
          src_ext_d = 1'b1;
        end else begin
          src_addr_d  = rval(i_src_reg);
          src_fetch_d = 1'b1;
          // stack pointer lives outside; only r4..r15 step here
          inc_d = (i_src_reg >= `COS_R_GP0);
        end
      end
      default: src_val_d = `COS_ZERO16;
    endcase
  end

  // destination decode, no indirect forms exist here
  always @* begin
    dst_val_d  = `COS_ZERO16;
    dst_addr_d = `COS_ZERO16;
    dst_mem_d  = 1'b0;
    dst_ext_d  = 1'b0;
    if (!i_dst_mode) begin
      dst_val_d = rval(i_dst_reg);
    end else begin
      dst_mem_d = 1'b1;
      dst_ext_d = 1'b1;
      if (i_dst_reg == `COS_R_SR)
        dst_addr_d = i_dst_ext;
      else
        dst_addr_d = rval(i_dst_reg) + i_dst_ext;
    end
  end

  // status word next value: alu, then writeback, then port
  always @* begin
    sr_d = sr_q;
    sa   = sgn(i_alu_a, i_alu_byte);
    sb   = sgn(i_alu_b, i_alu_byte);
    sres = sgn(i_alu_res, i_alu_byte);
    if (i_alu_valid) begin
      sr_d[`COS_SR_N] = sres;
      sr_d[`COS_SR_C] = i_alu_carry;
      if (i_alu_byte)
        sr_d[`COS_SR_Z] = ((i_alu_res & `COS_LO_MASK)
                           == `COS_ZERO16);
      else
        sr_d[`COS_SR_Z] = (i_alu_res == `COS_ZERO16);
      case (i_alu_kind)
        `COS_K_ADD: sr_d[`COS_SR_V] = (sa == sb) & (sres != sa);
        `COS_K_SUB: sr_d[`COS_SR_V] = (sa != sb) & (sres != sa);
        default:    sr_d[`COS_SR_V] = i_alu_v;
      endcase
    end
    // byte writes to the status word are not ordinary accesses
    if (i_wb_en && !i_wb_byte && i_wb_reg == `COS_R_SR)
      sr_d = i_wb_data[`COS_SR_W-1:0];
    if (i_reg_wr && i_reg_addr == `COS_R_SR)
      sr_d = i_reg_wdata[`COS_SR_W-1:0];
  end

  // writeback value with byte clearing
  always @* begin
    if (i_wb_byte)
      wb_val = i_wb_data & `COS_LO_MASK;
    else
      wb_val = i_wb_data;
  end

  // port read data, unmapped numbers read zero
  always @* begin
    if (i_reg_addr == `COS_R_SR)
      rd_d = {`COS_SR_PAD, sr_q};
    else if (i_reg_addr >= `COS_R_GP0)
      rd_d = gpr_q[gidx(i_reg_addr)];
    else
      rd_d = `COS_ZERO16;
  end

  // general registers
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      for (k = 0; k < `COS_NGPR; k = k + 1)
        gpr_q[k] <= `COS_ZERO16;
    end else begin
      if (i_dec_valid && inc_d) begin
        if (i_dec_byte)
          gpr_q[gidx(i_src_reg)] <= rval(i_src_reg) + `COS_INC_B;
        else
          gpr_q[gidx(i_src_reg)] <= rval(i_src_reg) + `COS_INC_W;
      end
      // constant register and pc/sp writes never land here
      if (i_wb_en && i_wb_reg >= `COS_R_GP0)
        gpr_q[gidx(i_wb_reg)] <= wb_val;
      if (i_reg_wr && i_reg_addr >= `COS_R_GP0)
        gpr_q[gidx(i_reg_addr)] <= i_reg_wdata;
    end
  end

  // status word and registered outputs
  always @(posedge i_sys_clk) begin
    if (i_sys_rst) begin
      sr_q           <= `COS_SR_RST;
      o_reg_rdata    <= `COS_ZERO16;
      o_dec_valid    <= 1'b0;
      o_src_val      <= `COS_ZERO16;
      o_src_addr     <= `COS_ZERO16;
      o_src_fetch    <= 1'b0;
      o_src_ext_used <= 1'b0;
      o_dst_val      <= `COS_ZERO16;
      o_dst_addr     <= `COS_ZERO16;
      o_dst_mem      <= 1'b0;
      o_dst_ext_used <= 1'b0;
      o_irq_take     <= 1'b0;
      o_core_halt    <= 1'b0;
      o_dco_dc_off   <= 1'b0;
      o_fll_hold     <= 1'b0;
      o_xtal_stop    <= 1'b0;
      o_status       <= `COS_ZERO16;
    end else begin
      sr_q        <= sr_d;
      o_reg_rdata <= i_reg_rd ? rd_d : `COS_ZERO16;
      o_dec_valid <= i_dec_valid;
      if (i_dec_valid) begin
        o_src_val      <= src_val_d;
        o_src_addr     <= src_addr_d;
        o_src_fetch    <= src_fetch_d;
        o_src_ext_used <= src_ext_d;
        o_dst_val      <= dst_val_d;
        o_dst_addr     <= dst_addr_d;
        o_dst_mem      <= dst_mem_d;
        o_dst_ext_used <= dst_ext_d;
      end
      // controls follow the stored word, one cycle behind
      o_irq_take   <= i_irq_req & sr_q[`COS_SR_GIE];
      o_core_halt  <= sr_q[`COS_SR_HALT];
      // an oscillator in use as a clock is never stopped
      o_dco_dc_off <= sr_q[`COS_SR_UCLK]
                      & ~(i_dco_main | i_dco_sub);
      o_fll_hold   <= sr_q[`COS_SR_LCLK];
      o_xtal_stop  <= sr_q[`COS_SR_XOFF]
                      & ~(i_xt_main | i_xt_sub);
      o_status     <= {`COS_SR_PAD, sr_q};
    end
  end

endmodule // cos_operand_status

//--- tb/cos_alu_model.sv
// alu partner model: result and carry for add and subtract kinds
`timescale 1ns/1ps
module cos_alu_model (
  // operation
  input  wire [1:0]  i_kind,
  input  wire        i_byte,
  input  wire [15:0] i_a,
  input  wire [15:0] i_b,
  // result
  output wire [15:0] o_res,
  output wire        o_carry
);
  // subtract as a plus inverted b plus one
  wire        sub = (i_kind == 2'h2);
  wire [15:0] bb  = sub ? ~i_b : i_b;
  wire [16:0] w   = {1'h0, i_a} + {1'h0, bb} + {16'h0000, sub};
  wire [8:0]  y   = {1'h0, i_a[7:0]} + {1'h0, bb[7:0]} + {8'h00, sub};
  assign o_res   = i_byte ? {8'h00, y[7:0]} : w[15:0];
  assign o_carry = i_byte ? y[8] : w[16];
endmodule // cos_alu_model

//--- tb/cos_checker.sv
// port assertions for the operand and status block
`timescale 1ns/1ps
module cos_checker (
  input wire        i_sys_clk, i_sys_rst, i_reg_wr, i_wb_en, i_irq_req,
  input wire        i_dco_main, i_dco_sub, i_xt_main, i_xt_sub,
  input wire        i_dec_valid, i_alu_valid, i_alu_byte,
  input wire [3:0]  i_src_reg,
  input wire [1:0]  i_src_mode,
  input wire [15:0] i_src_ext, i_alu_res,
  input wire        o_dec_valid, o_src_fetch, o_src_ext_used, o_irq_take,
  input wire        o_core_halt, o_dco_dc_off, o_fll_hold, o_xtal_stop,
  input wire [15:0] o_src_val, o_src_addr, o_status
);
  default clocking cb @(posedge i_sys_clk); endclocking
  default disable iff (i_sys_rst);
  property p_irq; o_irq_take == ($past(i_irq_req) && o_status[3]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq take wrong");
  property p_halt; o_core_halt == o_status[4]; endproperty
  a_halt: assert property (p_halt) else $error("halt wrong");
  property p_fll; o_fll_hold == o_status[6]; endproperty
  a_fll: assert property (p_fll) else $error("loop hold wrong");
  property p_dco;
    o_dco_dc_off == (o_status[7] && !$past(i_dco_main) && !$past(i_dco_sub));
  endproperty
  a_dco: assert property (p_dco) else $error("dc gen wrong");
  property p_xtal;
    o_xtal_stop == (o_status[5] && !$past(i_xt_main) && !$past(i_xt_sub));
  endproperty
  a_xtal: assert property (p_xtal) else $error("xtal wrong");
  property p_pad; o_status[15:9] == 7'h00; endproperty
  a_pad: assert property (p_pad) else $error("status pad");
  property p_dec; i_dec_valid |=> o_dec_valid; endproperty
  a_dec: assert property (p_dec) else $error("no decode ack");
  property p_const; i_dec_valid && i_src_reg == 4'h3 && i_src_mode == 2'h3
    |=> o_src_val == 16'hffff && !o_src_fetch; endproperty
  a_const: assert property (p_const) else $error("const wrong");
  property p_abs; i_dec_valid && i_src_reg == 4'h2 && i_src_mode == 2'h1
    |=> o_src_fetch && o_src_addr == $past(i_src_ext); endproperty
  a_abs: assert property (p_abs) else $error("absolute wrong");
  property p_imm; i_dec_valid && i_src_reg == 4'h0 && i_src_mode == 2'h3
    |=> o_src_ext_used && !o_src_fetch && o_src_val == $past(i_src_ext);
  endproperty
  a_imm: assert property (p_imm) else $error("immediate wrong");
  property p_nflag; i_alu_valid && !i_reg_wr && !i_wb_en |-> ##2
    o_status[2] == $past(i_alu_byte ? i_alu_res[7] : i_alu_res[15], 2);
  endproperty
  a_nflag: assert property (p_nflag) else $error("msb flag");
  property p_zflag; i_alu_valid && !i_reg_wr && !i_wb_en |-> ##2 o_status[1]
    == $past(i_alu_byte ? i_alu_res[7:0] == 8'h00 : i_alu_res == 16'h0000, 2);
  endproperty
  a_zflag: assert property (p_zflag) else $error("zero flag");
endmodule // cos_checker
bind cos_operand_status cos_checker u_chk (.i_sys_clk, .i_sys_rst,
  .i_reg_wr, .i_wb_en, .i_irq_req, .i_dco_main, .i_dco_sub, .i_xt_main,
  .i_xt_sub, .i_dec_valid, .i_alu_valid, .i_alu_byte, .i_src_reg,
  .i_src_mode, .i_src_ext, .i_alu_res, .o_dec_valid, .o_src_fetch,
  .o_src_ext_used, .o_irq_take, .o_core_halt, .o_dco_dc_off, .o_fll_hold,
  .o_xtal_stop, .o_src_val, .o_src_addr, .o_status);

//--- tb/tb_cos_operand_status.sv
// self-checking bench for the operand and status block
`timescale 1ns/1ps
module tb_cos_operand_status;
  logic i_sys_clk = 1'h0, i_sys_rst = 1'h1, i_reg_wr = 1'h0, i_reg_rd = 1'h0;
  logic i_dec_valid = 1'h0, i_dec_byte = 1'h0, i_dst_mode = 1'h0;
  logic i_alu_valid = 1'h0, i_alu_byte = 1'h0, i_alu_v = 1'h0;
  logic i_wb_en = 1'h0, i_wb_byte = 1'h0, i_irq_req = 1'h0;
  logic i_dco_main = 1'h0, i_dco_sub = 1'h0, i_xt_main = 1'h0, i_xt_sub = 1'h0;
  logic [3:0] i_reg_addr = 4'h0, i_src_reg = 4'h0;
  logic [3:0] i_dst_reg = 4'h0, i_wb_reg = 4'h0;
  logic [1:0] i_src_mode = 2'h0, i_alu_kind = 2'h0;
  logic [15:0] i_reg_wdata, i_src_ext, i_dst_ext, i_sp, i_alu_a, i_alu_b;
  logic [15:0] i_wb_data, i_pc, i_alu_res, o_reg_rdata, o_src_val;
  logic [15:0] o_src_addr, o_dst_val, o_dst_addr, o_status;
  logic i_alu_carry, o_dec_valid, o_src_fetch, o_src_ext_used, o_dst_mem;
  logic o_dst_ext_used, o_irq_take, o_core_halt, o_dco_dc_off;
  logic o_fll_hold, o_xtal_stop;
  integer bad_count = 0, checks_done = 0;
  always #2 i_sys_clk = ~i_sys_clk;
  cos_alu_model u_alu (.i_kind(i_alu_kind), .i_byte(i_alu_byte),
    .i_a(i_alu_a), .i_b(i_alu_b), .o_res(i_alu_res), .o_carry(i_alu_carry));
  cos_operand_status DUT (.i_sys_clk, .i_sys_rst, .i_reg_addr, .i_reg_wdata,
    .i_reg_wr, .i_reg_rd, .o_reg_rdata, .i_dec_valid, .i_dec_byte,
    .i_src_reg, .i_src_mode, .i_src_ext, .i_dst_reg, .i_dst_mode, .i_dst_ext,
    .i_pc, .i_sp, .o_dec_valid, .o_src_val, .o_src_addr, .o_src_fetch,
    .o_src_ext_used, .o_dst_val, .o_dst_addr, .o_dst_mem, .o_dst_ext_used,
    .i_alu_valid, .i_alu_kind, .i_alu_byte, .i_alu_a, .i_alu_b, .i_alu_res,
    .i_alu_carry, .i_alu_v, .i_wb_en, .i_wb_byte, .i_wb_reg, .i_wb_data,
    .i_irq_req, .i_dco_main, .i_dco_sub, .i_xt_main, .i_xt_sub, .o_irq_take,
    .o_core_halt, .o_dco_dc_off, .o_fll_hold, .o_xtal_stop, .o_status);
  task chk(input [15:0] got, input [15:0] exp);
    checks_done++;
    if (got !== exp) begin
      bad_count++;
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge i_sys_clk);
  endtask
  task wr(input [3:0] a, input [15:0] d);
    @(posedge i_sys_clk);
    i_reg_wr <= 1'h1; i_reg_addr <= a; i_reg_wdata <= d;
    @(posedge i_sys_clk);
    i_reg_wr <= 1'h0;
  endtask
  task rd(input [3:0] a, input [15:0] e);
    @(posedge i_sys_clk);
    i_reg_rd <= 1'h1; i_reg_addr <= a;
    @(posedge i_sys_clk);
    i_reg_rd <= 1'h0;
    #1 chk(o_reg_rdata, e);
  endtask
  task wb(input b, input [3:0] r, input [15:0] d);
    @(posedge i_sys_clk);
    i_wb_en <= 1'h1; i_wb_byte <= b; i_wb_reg <= r; i_wb_data <= d;
    @(posedge i_sys_clk);
    i_wb_en <= 1'h0;
  endtask
  task dec(input [3:0] r, input [1:0] m, input [15:0] x, input b);
    @(posedge i_sys_clk);
    i_dec_valid <= 1'h1; i_src_reg <= r; i_src_mode <= m;
    i_src_ext <= x; i_dec_byte <= b;
    @(posedge i_sys_clk);
    i_dec_valid <= 1'h0;
    #1;
  endtask
  task alu(input [1:0] k, input b, input [15:0] x, y, e);
    @(posedge i_sys_clk);
    i_alu_valid <= 1'h1; i_alu_kind <= k; i_alu_byte <= b;
    i_alu_a <= x; i_alu_b <= y;
    @(posedge i_sys_clk);
    i_alu_valid <= 1'h0;
    rd(4'h2, e);
  endtask
  function [15:0] pw();
    pw = {11'h0, o_irq_take, o_core_halt, o_fll_hold, o_dco_dc_off,
          o_xtal_stop};
  endfunction
  task t_regs;
    wr(4'h4, 16'h1234); wr(4'hf, 16'hbeef);
    rd(4'h4, 16'h1234); rd(4'hf, 16'hbeef);
    wr(4'h3, 16'h5555); rd(4'h3, 16'h0000);
    wr(4'h2, 16'hffff); rd(4'h2, 16'h01ff);
    wr(4'h2, 16'h0000);
    wb(1'h1, 4'h5, 16'habcd); rd(4'h5, 16'h00cd);
    wb(1'h1, 4'h2, 16'hffff); rd(4'h2, 16'h0000);
    $display("test regs done");
  endtask
  task t_consts;
    logic [15:0] k [0:5];
    k = '{16'h0000, 16'h0001, 16'h0002, 16'hffff, 16'h0004, 16'h0008};
    for (int i = 0; i < 6; i++) begin
      dec((i < 4) ? 4'h3 : 4'h2, (i < 4) ? i[1:0] : i[1:0] + 2'h2,
          16'h0000, 1'h0);
      chk(o_src_val, k[i]);
      chk({15'h0, o_src_fetch}, 16'h0000);
    end
    $display("test consts done");
  endtask
  task t_modes;
    wr(4'h5, 16'h1000); wr(4'h6, 16'h2000); wr(4'h7, 16'h3000);
    wr(4'h8, 16'h4000);
    dec(4'h5, 2'h1, 16'h0010, 1'h0); chk(o_src_addr, 16'h1010);
    dec(4'h0, 2'h1, 16'h0020, 1'h0); chk(o_src_addr, 16'h0120);
    dec(4'h2, 2'h1, 16'h0456, 1'h0); chk(o_src_addr, 16'h0456);
    dec(4'h6, 2'h2, 16'h0000, 1'h0); chk(o_src_addr, 16'h2000);
    dec(4'h7, 2'h3, 16'h0000, 1'h0); chk(o_src_addr, 16'h3000);
    dec(4'h7, 2'h3, 16'h0000, 1'h1); chk(o_src_addr, 16'h3002);
    rd(4'h7, 16'h3003);
    dec(4'h0, 2'h3, 16'h1357, 1'h0); chk(o_src_val, 16'h1357);
    chk({15'h0, o_src_ext_used}, 16'h0001);
    @(posedge i_sys_clk);
    i_dst_reg <= 4'h8; i_dst_mode <= 1'h1; i_dst_ext <= 16'h0004;
    dec(4'h5, 2'h0, 16'h0000, 1'h0); chk(o_src_val, 16'h1000);
    chk(o_dst_addr, 16'h4004);
    chk({15'h0, o_dst_mem}, 16'h0001);
    chk({15'h0, o_dst_ext_used}, 16'h0001);
    @(posedge i_sys_clk);
    i_dst_mode <= 1'h0;
    dec(4'h5, 2'h0, 16'h0000, 1'h0); chk(o_dst_val, 16'h4000);
    chk({15'h0, o_dst_mem}, 16'h0000);
    chk({15'h0, o_dst_ext_used}, 16'h0000);
    $display("test modes done");
  endtask
  task t_flags;
    alu(2'h1, 1'h0, 16'h7fff, 16'h0001, 16'h0104);
    alu(2'h1, 1'h1, 16'h0080, 16'h0080, 16'h0103);
    alu(2'h2, 1'h0, 16'h8000, 16'h0001, 16'h0101);
    alu(2'h2, 1'h0, 16'h0005, 16'h0005, 16'h0003);
    alu(2'h1, 1'h0, 16'h0001, 16'h0002, 16'h0000);
    $display("test flags done");
  endtask
  task t_power;
    wr(4'h2, 16'h00f8);
    i_irq_req <= 1'h1;
    cyc(3); #1 chk(pw(), 16'h001f);
    @(posedge i_sys_clk);
    i_dco_main <= 1'h1; i_xt_sub <= 1'h1;
    cyc(3); #1 chk(pw(), 16'h001c);
    @(posedge i_sys_clk);
    i_dco_main <= 1'h0; i_dco_sub <= 1'h1; i_xt_sub <= 1'h0; i_xt_main <= 1'h1;
    cyc(3); #1 chk(pw(), 16'h001c);
    wr(4'h2, 16'h0000);
    cyc(3); #1 chk(pw(), 16'h0000);
    @(posedge i_sys_clk);
    i_irq_req <= 1'h0;
    $display("test power done");
  endtask
  task close_out;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    {i_reg_wdata, i_src_ext, i_dst_ext, i_sp, i_alu_a, i_alu_b} = 96'h0;
    i_wb_data = 16'h0000;
    i_pc = 16'h0100;
    cyc(10);
    i_sys_rst <= 1'h0;
    t_regs; t_consts; t_modes; t_flags; t_power;
    close_out;
  end
  // whole run is about 120 cycles
  initial begin
    #40000;
    bad_count++;
    close_out;
  end
endmodule // tb_cos_operand_status
